/* File: core/dcdm_consts.svh */
`ifndef DCDM_CONSTS_SVH
`define DCDM_CONSTS_SVH
// Command line codes {ras_n, cas_n, we_n}
`define DCDM_CMD_ACT 3'h3
`define DCDM_CMD_PRE 3'h2
`define DCDM_CMD_RD 3'h5
`define DCDM_CMD_WR 3'h4
`define DCDM_CMD_MRS 3'h0
`define DCDM_CMD_REF 3'h1
`define DCDM_CMD_BST 3'h6
`define DCDM_CMD_NOP 3'h7
// Mode register field positions, and the auto-precharge address bit
`define DCDM_BL_LSB 0
`define DCDM_BT_BIT 3
`define DCDM_CL_LSB 4
`define DCDM_TM_LSB 7
`define DCDM_AP_BIT 10
// Burst length codes
`define DCDM_BL2 3'h1
`define DCDM_BL4 3'h2
`define DCDM_BL8 3'h3
// Read latency codes, latency kept in half clocks
`define DCDM_CL2 3'h2
`define DCDM_CL3 3'h3
`define DCDM_CL25 3'h6
`define DCDM_HALF_CL2 4'h4
`define DCDM_HALF_CL3 4'h6
`define DCDM_HALF_CL25 4'h5
// Mode load wait, in clocks
`define DCDM_MODE_LOAD_WAIT_CLK 2
`define DCDM_MODE_RESET 12'h000
`define DCDM_EXT_RESET 2'h0
`endif

/* File: core/dcdm_pkg.sv */
package dcdm_pkg;
  typedef enum logic [3:0] {
    DCDM_OP_NONE, DCDM_OP_ACT, DCDM_OP_PRE, DCDM_OP_PREA, DCDM_OP_RD,
    DCDM_OP_WR, DCDM_OP_MRS, DCDM_OP_EXTENDED_MODE_LOAD_COMMAND, DCDM_OP_BST, DCDM_OP_REF,
    DCDM_OP_SREF, DCDM_OP_EXIT, DCDM_OP_PDN
  } dcdm_op_t;
  typedef enum logic [1:0] {
    DCDM_PWR_RUN, DCDM_PWR_SELF, DCDM_PWR_PRE_PD, DCDM_PWR_ACT_PD
  } dcdm_pwr_t;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [1:0] dm;
  } dcdm_cmd_t;
  typedef struct packed {
    logic [1:0] ba;
    logic [2:0] test_mode;
    logic [2:0] latency;
    logic interleave;
    logic [2:0] burst_len;
  } dcdm_mode_t;
endpackage

/* File: core/dcdm_burst_seq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcdm_consts.svh"
module dcdm_burst_seq
  import dcdm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic [2:0] start_col,
  input wire logic [2:0] len_code,
  input wire logic interleave,
  // Burst order
  output logic active,
  output logic [2:0] col_offset,
  output logic last
);
  logic [2:0] count;
  logic [2:0] base;
  logic [2:0] mask;
  logic [2:0] len_mask;
  logic interleave_q;
  assign len_mask = (len_code == `DCDM_BL8) ? 3'h7 :
                    (len_code == `DCDM_BL4) ? 3'h3 : 3'h1;
  // Sequential adds and wraps in the block, interleaved XORs
  wire [2:0] seq_off = (base & ~mask) | ((base + count) & mask);
  wire [2:0] int_off = (base & ~mask) | ((base ^ count) & mask);
  assign col_offset = interleave_q ? int_off : seq_off;
  assign last = active && (count == mask);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active <= 1'b0;
      count <= 3'h0;
      base <= 3'h0;
      mask <= 3'h0;
      interleave_q <= 1'b0;
    end else if (start) begin
      active <= 1'b1;
      count <= 3'h0;
      base <= start_col;
      mask <= len_mask;
      interleave_q <= interleave;
    end else if (stop || last) begin
      active <= 1'b0;
      count <= 3'h0;
    end else if (active) begin
      count <= count + 3'h1;
    end
  end
endmodule
`default_nettype wire

/* File: core/dcdm_bank_state.sv */
`timescale 1ns/1ps
`default_nettype none
module dcdm_bank_state (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bank events
  input wire logic open_bank,
  input wire logic close_bank,
  // State
  output logic is_open
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      is_open <= 1'b0;
    end else if (open_bank) begin
      is_open <= 1'b1;
    end else if (close_bank) begin
      is_open <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: core/dcdm_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcdm_consts.svh"
module dcdm_decode
  import dcdm_pkg::*;
#(
  parameter int NUM_BANKS = 4,
  parameter int MODE_WAIT = `DCDM_MODE_LOAD_WAIT_CLK
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Command pins from the controller
  input wire dcdm_cmd_t cmd_pins,
  // Write data lanes
  input wire logic [15:0] wr_data,
  // Decoded command
  output dcdm_op_t op,
  output logic op_valid,
  output logic [1:0] op_bank,
  output logic [7:0] op_col,
  output logic op_auto_precharge,
  // Bank and power state
  output logic [NUM_BANKS-1:0] bank_open,
  output dcdm_pwr_t power_state,
  output logic auto_refresh,
  // Burst progress
  output logic burst_active,
  output logic [7:0] burst_col,
  output logic burst_is_write,
  // Masked write
  output logic [15:0] wr_accept_data,
  output logic [1:0] wr_byte_en,
  // Mode registers as in effect
  output dcdm_mode_t operating_mode_register,
  output logic [3:0] read_latency_half,
  output logic dll_reset_req,
  output logic test_mode,
  output logic dll_disable,
  output logic weak_drive,
  output logic mode_busy
);
  // Two-flop sync of every pin before decode
  dcdm_cmd_t meta;
  dcdm_cmd_t pins;
  logic cke_prev;
  // Data lanes take the same two flops, so they stay aligned with the masks
  logic [15:0] wr_meta;
  logic [15:0] wr_sync;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '1;
      pins <= '1;
      cke_prev <= 1'b1;
      wr_meta <= 16'h0000;
      wr_sync <= 16'h0000;
    end else begin
      meta <= cmd_pins;
      pins <= meta;
      cke_prev <= pins.cke;
      wr_meta <= wr_data;
      wr_sync <= wr_meta;
    end
  end

  wire [2:0] rcw = {pins.ras_n, pins.cas_n, pins.we_n};
  wire sel = !pins.cs_n;
  wire any_open = |bank_open;
  wire ap_bit = pins.addr[`DCDM_AP_BIT];
  wire running = (power_state == DCDM_PWR_RUN);
  wire nop_or_desel = !sel || (rcw == `DCDM_CMD_NOP);
  wire this_open = bank_open[pins.ba];
  logic mode_wait_done;

  // Commands need CKE high in the prior cycle
  wire go = running && cke_prev && sel && mode_wait_done;
  wire is_act = go && (rcw == `DCDM_CMD_ACT) && !this_open;
  wire is_pre = go && (rcw == `DCDM_CMD_PRE);
  wire is_rw = go && this_open &&
               (rcw == `DCDM_CMD_RD || rcw == `DCDM_CMD_WR);
  wire is_mrs = go && (rcw == `DCDM_CMD_MRS) && !any_open &&
                !burst_active;
  wire is_bst = go && (rcw == `DCDM_CMD_BST) && burst_active;
  wire is_ref = go && (rcw == `DCDM_CMD_REF) && !any_open;
  wire is_exit = !running && !cke_prev && pins.cke &&
                 nop_or_desel;
  wire is_pdn = running && cke_prev && !pins.cke && nop_or_desel &&
                mode_wait_done;

  // Decoded-command report
  dcdm_op_t next_op;
  always_comb begin
    next_op = DCDM_OP_NONE;
    if (is_act) next_op = DCDM_OP_ACT;
    else if (is_pre) next_op = ap_bit ? DCDM_OP_PREA : DCDM_OP_PRE;
    else if (is_rw) next_op = (rcw == `DCDM_CMD_RD) ? DCDM_OP_RD : DCDM_OP_WR;
    else if (is_mrs) next_op = pins.ba[0] ? DCDM_OP_EXTENDED_MODE_LOAD_COMMAND : DCDM_OP_MRS;
    else if (is_bst) next_op = DCDM_OP_BST;
    else if (is_ref) next_op = pins.cke ? DCDM_OP_REF : DCDM_OP_SREF;
    else if (is_exit) next_op = DCDM_OP_EXIT;
    else if (is_pdn) next_op = DCDM_OP_PDN;
  end

  // Auto-precharge closes the bank at the burst's end
  logic ap_pending;
  logic [1:0] ap_bank;
  logic burst_last;
  wire ap_fire = ap_pending && (burst_last || is_bst);

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      wire open_g = is_act && (pins.ba == g);
      wire close_g = (is_pre && (ap_bit || pins.ba == g)) ||
                     (ap_fire && ap_bank == g);
      dcdm_bank_state u_bank (
        .clk(clk),
        .rst_b(rst_b),
        .open_bank(open_g),
        .close_bank(close_g),
        .is_open(bank_open[g])
      );
    end
  endgenerate

  // Mode registers and their wait
  dcdm_mode_t mode;
  logic [1:0] ext_mode;
  logic [1:0] wait_cnt;
  assign mode_wait_done = (wait_cnt == 2'h0);
  wire mrs_load = (next_op == DCDM_OP_MRS) && !pins.ba[1];
  wire extended_mode_load_command_load = (next_op == DCDM_OP_EXTENDED_MODE_LOAD_COMMAND);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= dcdm_mode_t'(`DCDM_MODE_RESET);
      ext_mode <= `DCDM_EXT_RESET;
      wait_cnt <= 2'h0;
    end else begin
      if (mrs_load) begin
        mode <= {pins.ba, pins.addr[9:7], pins.addr[6:4], pins.addr[3],
                 pins.addr[2:0]};
      end
      if (extended_mode_load_command_load) begin
        ext_mode <= pins.addr[1:0];
      end
      if (mrs_load || extended_mode_load_command_load) begin
        wait_cnt <= 2'(MODE_WAIT - 1);
      end else if (!mode_wait_done) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end

  // Burst sequencer
  logic seq_active;
  logic [2:0] seq_off;
  logic [7:0] col_base;
  logic is_write_q;
  dcdm_burst_seq u_seq (
    .clk(clk),
    .rst_b(rst_b),
    .start(is_rw),
    .stop(is_bst),
    .start_col(pins.addr[2:0]),
    .len_code(mode.burst_len),
    .interleave(mode.interleave),
    .active(seq_active),
    .col_offset(seq_off),
    .last(burst_last)
  );

  // Outside a write burst no lane is enabled and the data reads as zero
  wire write_beat = seq_active && is_write_q;
  wire [1:0] next_byte_en = {2{write_beat}} & ~pins.dm;

  // Power and auto-precharge tracking
  dcdm_pwr_t next_pwr;
  always_comb begin
    next_pwr = power_state;
    if (is_exit) next_pwr = DCDM_PWR_RUN;
    else if (is_ref && !pins.cke) next_pwr = DCDM_PWR_SELF;
    else if (is_pdn) next_pwr = any_open ? DCDM_PWR_ACT_PD :
                                           DCDM_PWR_PRE_PD;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_state <= DCDM_PWR_RUN;
      ap_pending <= 1'b0;
      ap_bank <= 2'h0;
      col_base <= 8'h00;
      is_write_q <= 1'b0;
    end else begin
      power_state <= next_pwr;
      if (is_rw) begin
        ap_pending <= ap_bit;
        ap_bank <= pins.ba;
        col_base <= pins.addr[7:0];
        is_write_q <= (rcw == `DCDM_CMD_WR);
      end else if (ap_fire) begin
        ap_pending <= 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op <= DCDM_OP_NONE;
      op_valid <= 1'b0;
      op_bank <= 2'h0;
      op_col <= 8'h00;
      op_auto_precharge <= 1'b0;
      auto_refresh <= 1'b0;
      burst_col <= 8'h00;
      wr_accept_data <= 16'h0000;
      wr_byte_en <= 2'h0;
    end else begin
      op <= next_op;
      op_valid <= (next_op != DCDM_OP_NONE);
      op_bank <= pins.ba;
      op_col <= pins.addr[7:0];
      op_auto_precharge <= ap_bit;
      auto_refresh <= is_ref && pins.cke;
      burst_col <= {col_base[7:3], seq_off};
      // Each lane's mask acts alone; masked lanes read as zero
      wr_byte_en <= next_byte_en;
      wr_accept_data <= {next_byte_en[1] ? wr_sync[15:8] : 8'h00,
                         next_byte_en[0] ? wr_sync[7:0] : 8'h00};
    end
  end

  assign burst_active = seq_active;
  assign burst_is_write = is_write_q;
  assign operating_mode_register = mode;
  assign mode_busy = !mode_wait_done;
  assign read_latency_half =
    (mode.latency == `DCDM_CL2) ? `DCDM_HALF_CL2 :
    (mode.latency == `DCDM_CL3) ? `DCDM_HALF_CL3 :
    (mode.latency == `DCDM_CL25) ? `DCDM_HALF_CL25 : 4'h0;
  assign dll_reset_req = mode.test_mode[1] && !mode.test_mode[0];
  assign test_mode = mode.test_mode[0];
  assign dll_disable = ext_mode[0];
  assign weak_drive = ext_mode[1];
endmodule
`default_nettype wire

/* File: verification/dcdm_decode_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcdm_consts.svh"
module dcdm_decode_chk
  import dcdm_pkg::*;
#(
  parameter int NUM_BANKS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports
  input wire dcdm_cmd_t cmd_pins,
  input wire dcdm_op_t op,
  input wire logic op_valid,
  input wire logic [1:0] op_bank,
  input wire logic [NUM_BANKS-1:0] bank_open,
  input wire dcdm_pwr_t power_state,
  input wire logic auto_refresh,
  input wire logic [15:0] wr_accept_data,
  input wire logic [1:0] wr_byte_en,
  input wire dcdm_mode_t operating_mode_register,
  input wire logic [3:0] read_latency_half,
  input wire logic dll_disable,
  input wire logic weak_drive
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic [2:0] lat = operating_mode_register.latency;
  wire logic [15:0] lane_mask = {{8{wr_byte_en[1]}}, {8{wr_byte_en[0]}}};
  op_flag_a: assert property (op_valid == (op != DCDM_OP_NONE))
    else $error("op_valid disagrees with op");
  act_open_a: assert property (op_valid && op == DCDM_OP_ACT |-> bank_open[op_bank])
    else $error("activate left bank closed");
  pre_one_a: assert property (op_valid && op == DCDM_OP_PRE |-> !bank_open[op_bank])
    else $error("precharge left bank open");
  pre_all_a: assert property (op_valid && op == DCDM_OP_PREA |-> bank_open == '0)
    else $error("precharge all left a bank open");
  idle_quiet_a: assert property ((cmd_pins.cs_n && cmd_pins.cke) [*5] |-> !op_valid)
    else $error("deselect produced a command");
  refresh_pulse_a: assert property (auto_refresh |-> bank_open == '0 ##1 !auto_refresh)
    else $error("bad refresh pulse");
  self_ref_a: assert property (op_valid && op == DCDM_OP_SREF |-> ##[0:1] power_state == DCDM_PWR_SELF)
    else $error("self refresh not entered");
  lane_mask_a: assert property ((wr_accept_data & lane_mask) == wr_accept_data)
    else $error("masked lane carries data");
  latency_map_a: assert property (read_latency_half == (lat == `DCDM_CL2 ? `DCDM_HALF_CL2 :
    lat == `DCDM_CL3 ? `DCDM_HALF_CL3 : lat == `DCDM_CL25 ? `DCDM_HALF_CL25 : 4'h0))
    else $error("latency decode wrong");
  mode_hold_a: assert property ($changed(operating_mode_register) |-> op_valid && op == DCDM_OP_MRS)
    else $error("mode changed without load");
  ext_hold_a: assert property ($changed({dll_disable, weak_drive}) |-> op_valid && op == DCDM_OP_EXTENDED_MODE_LOAD_COMMAND)
    else $error("extended mode changed without load");
endmodule
bind dcdm_decode dcdm_decode_chk #(.NUM_BANKS(NUM_BANKS)) u_dcdm_decode_chk (
  .clk(clk), .rst_b(rst_b), .cmd_pins(cmd_pins), .op(op), .op_valid(op_valid),
  .op_bank(op_bank), .bank_open(bank_open), .power_state(power_state),
  .auto_refresh(auto_refresh), .wr_accept_data(wr_accept_data),
  .wr_byte_en(wr_byte_en), .operating_mode_register(operating_mode_register),
  .read_latency_half(read_latency_half), .dll_disable(dll_disable),
  .weak_drive(weak_drive));
`default_nettype wire

/* File: verification/dcdm_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcdm_consts.svh"
module dcdm_ctrl_model
  import dcdm_pkg::*;
(
  // Clock
  input wire logic clk,
  // Pins toward the device
  output var dcdm_cmd_t cmd_pins,
  output var logic [15:0] wr_data
);
  logic [1:0] dm_q = 2'h0;
  logic last_mrs = 1'b0;
  initial begin
    cmd_pins = {5'h1F, 2'h0, 12'h000, 2'h0};
    wr_data = 16'h0000;
  end
  task automatic set_data(input logic [1:0] dm, input logic [15:0] data);
    dm_q = dm;
    wr_data = data;
  endtask
  // Deselect with the given clock enable; address lines show no stale value
  task automatic idle(input logic cke);
    @(negedge clk);
    cmd_pins = {1'b1, 3'h7, cke, ~cmd_pins.ba, ~cmd_pins.addr, dm_q};
  endtask
  task automatic issue(input logic [2:0] code, input logic [1:0] ba,
      input logic [11:0] addr, input logic cke);
    logic [11:0] a;
    a = addr;
    if (last_mrs)
      repeat (`DCDM_MODE_LOAD_WAIT_CLK) @(negedge clk);
    if (code == `DCDM_CMD_MRS && ba == 2'h0)
      a[11:7] = 5'h00;
    @(negedge clk);
    cmd_pins = {1'b0, code, cke, ba, a, dm_q};
    last_mrs = (code == `DCDM_CMD_MRS);
    idle(cke);
  endtask
endmodule
`default_nettype wire

/* File: verification/ddr_command_decode_mode_register_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcdm_consts.svh"
module ddr_command_decode_mode_register_tb
  import dcdm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  dcdm_cmd_t cmd_pins;
  dcdm_op_t op;
  dcdm_pwr_t power_state;
  dcdm_mode_t operating_mode_register;
  logic op_valid, op_auto_precharge, auto_refresh, burst_active;
  logic dll_disable, weak_drive;
  logic [1:0] op_bank, wr_byte_en, en_seen;
  logic [7:0] op_col, burst_col;
  logic [3:0] bank_open, read_latency_half;
  logic [15:0] wr_data, wr_accept_data, dat_seen;
  logic [7:0] beats[$];
  int n_fail = 0;
  int total_checks = 0;
  dcdm_ctrl_model u_dcdm_ctrl_model (.clk(clk), .cmd_pins(cmd_pins),
    .wr_data(wr_data));
  dcdm_decode u_dcdm_decode (.clk(clk), .rst_b(rst_b), .cmd_pins(cmd_pins),
    .wr_data(wr_data), .op(op), .op_valid(op_valid), .op_bank(op_bank),
    .op_col(op_col), .op_auto_precharge(op_auto_precharge),
    .bank_open(bank_open), .power_state(power_state),
    .auto_refresh(auto_refresh), .burst_active(burst_active),
    .burst_col(burst_col), .burst_is_write(), .wr_accept_data(wr_accept_data),
    .wr_byte_en(wr_byte_en), .operating_mode_register(operating_mode_register),
    .read_latency_half(read_latency_half), .dll_reset_req(), .test_mode(),
    .dll_disable(dll_disable), .weak_drive(weak_drive), .mode_busy());
  initial forever #2 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // A refused command simply times out here and leaves op at none
  task automatic wait_op(input dcdm_op_t exp);
    for (int i = 0; i < 8 && op_valid !== 1'b1; i++) @(negedge clk);
    chk("op", 16'(exp), 16'(op));
  endtask
  task automatic collect();
    bit was;
    beats = {};
    en_seen = 2'h0;
    was = 1'b0;
    repeat (20) begin
      // The beat column trails burst_active by one cycle
      if (was) beats.push_back(burst_col);
      was = (burst_active === 1'b1);
      if (wr_byte_en !== 2'h0) begin
        en_seen = wr_byte_en;
        dat_seen = wr_accept_data;
      end
      @(negedge clk);
    end
  endtask
  task automatic chk_beats(input logic [7:0] s, input int len, input bit ilv);
    logic [7:0] m, e;
    m = 8'(len - 1);
    chk("beats", 16'(len), 16'(beats.size()));
    for (int i = 0; i < len && i < beats.size(); i++) begin
      e = (s & ~m) | ((ilv ? (s ^ 8'(i)) : (s + 8'(i))) & m);
      chk("burst col", {8'h00, e}, {8'h00, beats[i]});
    end
  endtask
  task automatic chk_pwr(input dcdm_pwr_t exp);
    repeat (6) @(negedge clk);
    chk("power", 16'(exp), 16'(power_state));
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    u_dcdm_ctrl_model.issue(`DCDM_CMD_MRS, 2'h0, 12'h032, 1'b1);
    wait_op(DCDM_OP_MRS);
    chk("mode", 16'h0032, 16'(operating_mode_register));
    chk("latency", 16'h0006, 16'(read_latency_half));
    u_dcdm_ctrl_model.issue(`DCDM_CMD_MRS, 2'h1, 12'h003, 1'b1);
    wait_op(DCDM_OP_EXTENDED_MODE_LOAD_COMMAND);
    chk("ext", 16'h0003, {14'h0, weak_drive, dll_disable});
    chk("mode kept", 16'h0032, 16'(operating_mode_register));
    $display("test modes done");
    u_dcdm_ctrl_model.issue(`DCDM_CMD_RD, 2'h1, 12'h405, 1'b1);
    wait_op(DCDM_OP_NONE);
    chk("burst", 16'h0000, 16'(burst_active));
    u_dcdm_ctrl_model.issue(`DCDM_CMD_ACT, 2'h1, 12'h123, 1'b1);
    wait_op(DCDM_OP_ACT);
    u_dcdm_ctrl_model.issue(`DCDM_CMD_RD, 2'h1, 12'h405, 1'b1);
    wait_op(DCDM_OP_RD);
    chk("col", 16'h0105, {7'h00, op_auto_precharge, op_col});
    collect();
    chk_beats(8'h05, 4, 1'b0);
    chk("open", 16'h0000, 16'(bank_open));
    $display("test read done");
    u_dcdm_ctrl_model.issue(`DCDM_CMD_MRS, 2'h0, 12'h02B, 1'b1);
    wait_op(DCDM_OP_MRS);
    chk("latency", 16'h0004, 16'(read_latency_half));
    u_dcdm_ctrl_model.issue(`DCDM_CMD_ACT, 2'h2, 12'h001, 1'b1);
    wait_op(DCDM_OP_ACT);
    u_dcdm_ctrl_model.set_data(2'h2, 16'hA55A);
    u_dcdm_ctrl_model.issue(`DCDM_CMD_WR, 2'h2, 12'h013, 1'b1);
    wait_op(DCDM_OP_WR);
    collect();
    chk_beats(8'h13, 8, 1'b1);
    chk("lanes", 16'h0001, 16'(en_seen));
    chk("data", 16'h005A, dat_seen);
    chk("open", 16'h0004, 16'(bank_open));
    $display("test write done");
    u_dcdm_ctrl_model.issue(`DCDM_CMD_ACT, 2'h3, 12'h000, 1'b1);
    wait_op(DCDM_OP_ACT);
    u_dcdm_ctrl_model.issue(`DCDM_CMD_RD, 2'h3, 12'h400, 1'b1);
    wait_op(DCDM_OP_RD);
    u_dcdm_ctrl_model.issue(`DCDM_CMD_BST, 2'h0, 12'h000, 1'b1);
    wait_op(DCDM_OP_BST);
    chk("stopped", 16'h0000, 16'(burst_active));
    chk("open", 16'h0004, 16'(bank_open));
    $display("test stop done");
    u_dcdm_ctrl_model.issue(`DCDM_CMD_BST, 2'h0, 12'h000, 1'b1);
    wait_op(DCDM_OP_NONE);
    u_dcdm_ctrl_model.issue(`DCDM_CMD_ACT, 2'h0, 12'h002, 1'b1);
    wait_op(DCDM_OP_ACT);
    u_dcdm_ctrl_model.issue(`DCDM_CMD_PRE, 2'h2, 12'h000, 1'b1);
    wait_op(DCDM_OP_PRE);
    chk("open", 16'h0001, 16'(bank_open));
    u_dcdm_ctrl_model.idle(1'b0);
    chk_pwr(DCDM_PWR_ACT_PD);
    u_dcdm_ctrl_model.idle(1'b1);
    chk_pwr(DCDM_PWR_RUN);
    u_dcdm_ctrl_model.issue(`DCDM_CMD_PRE, 2'h2, 12'h400, 1'b1);
    wait_op(DCDM_OP_PREA);
    u_dcdm_ctrl_model.idle(1'b0);
    chk_pwr(DCDM_PWR_PRE_PD);
    u_dcdm_ctrl_model.idle(1'b1);
    chk_pwr(DCDM_PWR_RUN);
    u_dcdm_ctrl_model.issue(`DCDM_CMD_REF, 2'h0, 12'h000, 1'b1);
    wait_op(DCDM_OP_REF);
    u_dcdm_ctrl_model.issue(`DCDM_CMD_REF, 2'h0, 12'h000, 1'b0);
    wait_op(DCDM_OP_SREF);
    u_dcdm_ctrl_model.idle(1'b1);
    chk_pwr(DCDM_PWR_RUN);
    $display("test power done");
    report_and_stop();
  end
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
